// File: include/acs_consts.svh
// register map, field positions, reset values and startup counts of the converter control block
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

`define ACS_ADDR_CTRL      8'h00
`define ACS_ADDR_TRIM      8'h04
`define ACS_ADDR_STAT      8'h08
`define ACS_ADDR_WORDS     8'h0c
`define ACS_ADDR_CODE_BASE 8'h10
`define ACS_ADDR_CODE_LAST 8'h2c
`define ACS_ADDR_PWRCM     8'h50

`define ACS_CTRL_RANGE_LSB 0
`define ACS_CTRL_PD_BIT    2
`define ACS_CTRL_DS_BIT    3
`define ACS_CTRL_MODE_BIT  4

`define ACS_PWR_LSB        0
`define ACS_CM_LSB         4

`define ACS_STAT_BUSY_BIT  0
`define ACS_STAT_VALID_BIT 1
`define ACS_STAT_RSVD_BIT  2

`define ACS_RST_RANGE      2'h0
`define ACS_RST_TRIM       6'h20
`define ACS_RST_PWR        3'h0
`define ACS_RST_CM         2'h1

`define ACS_CNT_RANGE0     10'h3e0
`define ACS_CNT_RANGE1     10'h280
`define ACS_CNT_RANGE2     10'h1a4
`define ACS_CNT_RANGE3     10'h104

`define ACS_LEN_SHORT      4'hc
`define ACS_LEN_LONG       4'he
`define ACS_CHANNELS       8

`endif

// File: include/acs_pkg.sv
// types and shared functions of the converter control block
`include "acs_consts.svh"

package acs_pkg;

	typedef logic [1:0]                      acs_range_t;
	typedef logic [12:0]                     acs_code_t;
	typedef logic [13:0]                     acs_word_t;
	typedef logic [`ACS_CHANNELS-1:0][12:0]  acs_codes_t;
	typedef logic [`ACS_CHANNELS-1:0][13:0]  acs_words_t;

	typedef enum logic [1:0] {SU_READY, SU_LOWPWR, SU_COUNT} acs_su_state_t;

	function automatic logic [9:0] acs_terminal(input acs_range_t range);
		unique case (range)
			2'h0: acs_terminal = `ACS_CNT_RANGE0;
			2'h1: acs_terminal = `ACS_CNT_RANGE1;
			2'h2: acs_terminal = `ACS_CNT_RANGE2;
			2'h3: acs_terminal = `ACS_CNT_RANGE3;
		endcase
	endfunction : acs_terminal

	// short words lose the lowest bit, long words gain a zero below it
	function automatic acs_word_t acs_format(input acs_code_t code, input logic long14);
		if (long14) begin
			acs_format = {code, 1'b0};
		end else begin
			acs_format = {2'h0, code[12:1]};
		end
	endfunction : acs_format

	function automatic logic acs_reserved_pwr(input logic [2:0] code);
		acs_reserved_pwr = (code != 3'h0) && !code[2];
	endfunction : acs_reserved_pwr

endpackage : acs_pkg

// File: verilog/acs_startup.sv
// startup delay counter run on every exit from power-down or deep-sleep
`timescale 1ns/1ps

module acs_startup
	import acs_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       powerDown,
	input  wire logic       deepSleep,
	input  wire acs_range_t clockRange,
	output logic            startupDone,
	output logic [9:0]      countValue
);

	acs_su_state_t stateFf;
	logic [9:0]    terminalFf;
	logic          lowPower;

	assign lowPower = powerDown | deepSleep;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			stateFf     <= SU_READY;
			startupDone <= 1'b1;
			countValue  <= 10'h000;
			terminalFf  <= `ACS_CNT_RANGE0;
		end else begin
			unique case (stateFf)
				SU_READY: begin
					if (lowPower) begin
						stateFf     <= SU_LOWPWR;
						startupDone <= 1'b0;
					end
				end
				SU_LOWPWR: begin
					if (!lowPower) begin
						stateFf    <= SU_COUNT;
						countValue <= 10'h000;
						terminalFf <= acs_terminal(clockRange);
					end
				end
				SU_COUNT: begin
					if (lowPower) begin
						stateFf <= SU_LOWPWR;
					end else if (countValue == terminalFf - 10'h001) begin
						stateFf     <= SU_READY;
						startupDone <= 1'b1;
					end else begin
						countValue <= countValue + 10'h001;
					end
				end
			endcase
		end
	end

endmodule : acs_startup

// File: verilog/acs_serializer.sv
// eight-lane serializer with bit and frame clocks, running on the link clock
`timescale 1ns/1ps

module acs_serializer
	import acs_pkg::*;
(
	input  wire logic                     ser_clk,
	input  wire logic                     sys_rst,
	input  wire logic                     reqToggle,
	input  wire acs_words_t               shadowWords,
	input  wire logic                     shadowLong,
	output logic                          ackToggle,
	output logic [`ACS_CHANNELS-1:0]      serData,
	output logic                          bitClk,
	output logic                          frameClk
);

	logic       rstMeta, serRst, reqMeta, reqSync;
	acs_words_t shiftFf;
	logic       longFf;
	logic [3:0] bitIdxFf;
	logic [3:0] frameLen;
	logic [3:0] nxt_bitIdx;

	// reset and request enter this domain through two flops each
	always_ff @(posedge ser_clk) begin
		rstMeta <= sys_rst;
		serRst  <= rstMeta;
		reqMeta <= reqToggle;
		reqSync <= reqMeta;
	end

	assign frameLen   = longFf ? `ACS_LEN_LONG : `ACS_LEN_SHORT;
	assign nxt_bitIdx = (bitIdxFf == frameLen - 4'h1) ? 4'h0 : bitIdxFf + 4'h1;

	always_ff @(posedge ser_clk) begin
		if (serRst) begin
			bitIdxFf  <= 4'h0;
			shiftFf   <= '0;
			longFf    <= 1'b0;
			ackToggle <= 1'b0;
			serData   <= '0;
			bitClk    <= 1'b0;
			frameClk  <= 1'b0;
		end else begin
			bitIdxFf <= nxt_bitIdx;
			bitClk   <= ~bitClk;
			frameClk <= (nxt_bitIdx < (frameLen >> 1));
			if (bitIdxFf == frameLen - 4'h1) begin
				// an idle frame of zeros keeps both clocks running when no sample waits
				if (reqSync != ackToggle) begin
					longFf    <= shadowLong;
					ackToggle <= reqSync;
					for (int ch = 0; ch < `ACS_CHANNELS; ch++) begin
						serData[ch]    <= shadowWords[ch][0];
						shiftFf[ch]    <= shadowWords[ch] >> 1;
					end
				end else begin
					serData <= '0;
					shiftFf <= '0;
				end
			end else begin
				for (int ch = 0; ch < `ACS_CHANNELS; ch++) begin
					serData[ch] <= shiftFf[ch][0];
					shiftFf[ch] <= shiftFf[ch] >> 1;
				end
			end
		end
	end

endmodule : acs_serializer

// File: verilog/acs_ctrl_top.sv
// converter control top: apb registers, startup timing and sample hand-off to the serializer
// Behaviour
// - startup count is 992, 640, 420 or 260 cycles by clock range; 00 default
// - clock range only affects startup after power-down or deep-sleep exit
// - six-bit trim code, 100000 means no change, monotonic steps
// - power level in bits 2..0 at 0x50, default 000, 001..011 reserved
// - buffer strength in bits 5..4 at 0x50: off, default weak, stronger
// - each channel's word is serialized on its own lane, common sample clock
// - serializer runs at twelve times frame rate in short mode, fourteen in long mode; bit and frame clocks output
// - code zero is most negative input, 8191 most positive, linear
// - short mode drops lowest bit; long mode appends zero; one setting selects
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps

module acs_ctrl_top
	import acs_pkg::*;
(
	input  wire logic                     ref_clk,
	input  wire logic                     sys_rst,
	input  wire logic                     ser_clk,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire acs_codes_t               convCode,
	output logic [5:0]                    full_scale_trim_code,
	output logic [2:0]                    powerLevel,
	output logic [1:0]                    common_mode_buffer_strength,
	output logic                          powerDownOut,
	output logic                          deepSleepOut,
	output logic                          dataValid,
	output logic [`ACS_CHANNELS-1:0]      serData,
	output logic                          bitClk,
	output logic                          frame_clock
);

	// control register fields, sticky refusal flag and sent-word count
	acs_range_t   clockRange_ff;
	logic         powerDown_ff;
	logic         deepSleep_ff;
	logic         longMode_ff;
	logic         rsvdWrite_ff;
	logic [15:0]  wordsSent_ff;

	// apb decode
	logic         setup;
	logic         access;
	logic         wrDone;
	logic         mapped;
	logic [31:0]  nxt_rdata;

	// startup
	logic         startupDone;
	logic [9:0]   startupCount;

	// hand-off toward the link domain
	logic         reqToggle_ff;
	acs_words_t   shadowWords_ff;
	logic         shadowLong_ff;
	logic         ackToggle;
	logic         ackMeta_ff;
	logic         ackSync_ff;
	logic         ackSeen_ff;
	acs_codes_t   lastCode_ff;

	assign setup  = psel & ~penable;
	assign access = psel & penable & pready;
	assign wrDone = access & pwrite & ~pslverr;

	function automatic logic acs_is_mapped(input logic [7:0] addr);
		acs_is_mapped = (addr == `ACS_ADDR_CTRL) || (addr == `ACS_ADDR_TRIM) ||
		                (addr == `ACS_ADDR_STAT) || (addr == `ACS_ADDR_WORDS) ||
		                (addr == `ACS_ADDR_PWRCM) ||
		                ((addr >= `ACS_ADDR_CODE_BASE) && (addr <= `ACS_ADDR_CODE_LAST) && (addr[1:0] == 2'h0));
	endfunction : acs_is_mapped

	assign mapped = acs_is_mapped(paddr);

	// every access completes with no wait state; pready follows the setup cycle
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
		end
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (paddr == `ACS_ADDR_CTRL) begin
			nxt_rdata[`ACS_CTRL_RANGE_LSB +: 2] = clockRange_ff;
			nxt_rdata[`ACS_CTRL_PD_BIT]         = powerDown_ff;
			nxt_rdata[`ACS_CTRL_DS_BIT]         = deepSleep_ff;
			nxt_rdata[`ACS_CTRL_MODE_BIT]       = longMode_ff;
		end else if (paddr == `ACS_ADDR_TRIM) begin
			nxt_rdata[5:0] = full_scale_trim_code;
		end else if (paddr == `ACS_ADDR_STAT) begin
			nxt_rdata[`ACS_STAT_BUSY_BIT]  = ~startupDone;
			nxt_rdata[`ACS_STAT_VALID_BIT] = dataValid;
			nxt_rdata[`ACS_STAT_RSVD_BIT]  = rsvdWrite_ff;
			nxt_rdata[25:16]               = startupCount;
		end else if (paddr == `ACS_ADDR_WORDS) begin
			nxt_rdata[15:0] = wordsSent_ff;
		end else if (paddr == `ACS_ADDR_PWRCM) begin
			nxt_rdata[`ACS_PWR_LSB +: 3] = powerLevel;
			nxt_rdata[`ACS_CM_LSB +: 2]  = common_mode_buffer_strength;
		end else if ((paddr >= `ACS_ADDR_CODE_BASE) && (paddr <= `ACS_ADDR_CODE_LAST)) begin
			// straight binary: zero is the most negative input
			nxt_rdata[12:0] = lastCode_ff[3'(paddr[4:2] - 3'h4)];
		end
	end

	// read data is captured in setup and held through the access cycle
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
		end else if (setup) begin
			prdata <= (!pwrite && mapped) ? nxt_rdata : 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			clockRange_ff <= `ACS_RST_RANGE;
			powerDown_ff  <= 1'b0;
			deepSleep_ff  <= 1'b0;
			longMode_ff   <= 1'b0;
		end else if (wrDone && paddr == `ACS_ADDR_CTRL) begin
			clockRange_ff <= pwdata[`ACS_CTRL_RANGE_LSB +: 2];
			powerDown_ff  <= pwdata[`ACS_CTRL_PD_BIT];
			deepSleep_ff  <= pwdata[`ACS_CTRL_DS_BIT];
			longMode_ff   <= pwdata[`ACS_CTRL_MODE_BIT];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			powerDownOut <= 1'b0;
			deepSleepOut <= 1'b0;
		end else begin
			powerDownOut <= powerDown_ff;
			deepSleepOut <= deepSleep_ff;
		end
	end

	// analog trim code; the range step per code is fixed by the analog dac
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			full_scale_trim_code <= `ACS_RST_TRIM;
		end else if (wrDone && paddr == `ACS_ADDR_TRIM) begin
			full_scale_trim_code <= pwdata[5:0];
		end
	end

	// a reserved power code is refused so the core never sees it
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			powerLevel                  <= `ACS_RST_PWR;
			common_mode_buffer_strength <= `ACS_RST_CM;
		end else if (wrDone && paddr == `ACS_ADDR_PWRCM) begin
			if (!acs_reserved_pwr(pwdata[`ACS_PWR_LSB +: 3])) begin
				powerLevel <= pwdata[`ACS_PWR_LSB +: 3];
			end
			common_mode_buffer_strength <= pwdata[`ACS_CM_LSB +: 2];
		end
	end

	// sticky flag: a fresh refusal wins over a clear in the same write
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rsvdWrite_ff <= 1'b0;
		end else if (wrDone && paddr == `ACS_ADDR_PWRCM && acs_reserved_pwr(pwdata[`ACS_PWR_LSB +: 3])) begin
			rsvdWrite_ff <= 1'b1;
		end else if (wrDone && paddr == `ACS_ADDR_STAT && pwdata[`ACS_STAT_RSVD_BIT]) begin
			rsvdWrite_ff <= 1'b0;
		end
	end

	acs_startup u_startup (
		.ref_clk     (ref_clk),
		.sys_rst     (sys_rst),
		.powerDown   (powerDown_ff),
		.deepSleep   (deepSleep_ff),
		.clockRange  (clockRange_ff),
		.startupDone (startupDone),
		.countValue  (startupCount)
	);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			dataValid <= 1'b0;
		end else begin
			dataValid <= startupDone & ~powerDown_ff & ~deepSleep_ff;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			lastCode_ff <= '0;
		end else begin
			lastCode_ff <= convCode;
		end
	end

	// ack comes back as a toggle through two flops
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ackMeta_ff <= 1'b0;
			ackSync_ff <= 1'b0;
			ackSeen_ff <= 1'b0;
		end else begin
			ackMeta_ff <= ackToggle;
			ackSync_ff <= ackMeta_ff;
			ackSeen_ff <= ackSync_ff;
		end
	end

	// the link takes one sample per frame; samples arriving meanwhile are not sent
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reqToggle_ff   <= 1'b0;
			shadowWords_ff <= '0;
			shadowLong_ff  <= 1'b0;
		end else if (dataValid && reqToggle_ff == ackSync_ff) begin
			reqToggle_ff  <= ~reqToggle_ff;
			shadowLong_ff <= longMode_ff;
			for (int ch = 0; ch < `ACS_CHANNELS; ch++) begin
				shadowWords_ff[ch] <= acs_format(lastCode_ff[ch], longMode_ff);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wordsSent_ff <= 16'h0000;
		end else if (ackSync_ff != ackSeen_ff) begin
			wordsSent_ff <= wordsSent_ff + 16'h0001;
		end
	end

	acs_serializer u_serializer (
		.ser_clk     (ser_clk),
		.sys_rst     (sys_rst),
		.reqToggle   (reqToggle_ff),
		.shadowWords (shadowWords_ff),
		.shadowLong  (shadowLong_ff),
		.ackToggle   (ackToggle),
		.serData     (serData),
		.bitClk      (bitClk),
		.frameClk    (frame_clock)
	);

endmodule : acs_ctrl_top

// File: test/acs_ctrl_top_sva.sv
// concurrent checks on the ports of the converter control top
`timescale 1ns/1ps

module acs_ctrl_top_sva
	import acs_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic        ser_clk,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [5:0]  full_scale_trim_code,
	input wire logic [2:0]  powerLevel,
	input wire logic [1:0]  common_mode_buffer_strength,
	input wire logic        powerDownOut,
	input wire logic        deepSleepOut,
	input wire logic        dataValid,
	input wire logic        bitClk
);
	logic       accWr;
	logic [9:0] quietCnt_ff;
	assign accWr = psel && penable && pready && pwrite;
	// saturates so the valid flag after reset is not taken for a short count
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			quietCnt_ff <= 10'h3ff;
		end else if (powerDownOut || deepSleepOut) begin
			quietCnt_ff <= 10'h000;
		end else if (quietCnt_ff != 10'h3ff) begin
			quietCnt_ff <= quietCnt_ff + 10'h001;
		end
	end
	apb_answer_a: assert property (@(posedge ref_clk) disable iff (sys_rst) psel && !penable |=> pready)
		else $error("no answer after setup");
	ready_access_a: assert property (@(posedge ref_clk) disable iff (sys_rst) pready |-> psel && penable)
		else $error("ready outside access");
	unmapped_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		pready && !pwrite && paddr == 8'h60 |-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	trim_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accWr && paddr == 8'h04 |=> full_scale_trim_code == $past(pwdata[5:0]))
		else $error("trim not written");
	cm_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accWr && paddr == 8'h50 |=> common_mode_buffer_strength == $past(pwdata[5:4]))
		else $error("buffer strength not written");
	pwr_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accWr && paddr == 8'h50 && (pwdata[2] || pwdata[2:0] == 3'h0) |=> powerLevel == $past(pwdata[2:0]))
		else $error("power level not written");
	pwr_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accWr && paddr == 8'h50 && !pwdata[2] && pwdata[1:0] != 2'h0 |=> $stable(powerLevel))
		else $error("reserved power code taken");
	startup_len_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(dataValid) |-> quietCnt_ff >= 10'd258)
		else $error("valid before startup count");
	lowpwr_invalid_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(powerDownOut || deepSleepOut) ##1 (powerDownOut || deepSleepOut) |-> !dataValid)
		else $error("valid in low power");
	bitclk_toggle_a: assert property (@(posedge ser_clk) disable iff (sys_rst)
		!$past(sys_rst, 6) |-> bitClk != $past(bitClk))
		else $error("bit clock stalled");
endmodule : acs_ctrl_top_sva

bind acs_ctrl_top acs_ctrl_top_sva acs_ctrl_top_sva_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .ser_clk(ser_clk),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .full_scale_trim_code(full_scale_trim_code), .powerLevel(powerLevel),
	.common_mode_buffer_strength(common_mode_buffer_strength), .powerDownOut(powerDownOut),
	.deepSleepOut(deepSleepOut), .dataValid(dataValid), .bitClk(bitClk));

// File: test/acs_lvds_rx.sv
// receiving logic model: rebuilds each lane's word from the frame clock
`timescale 1ns/1ps

module acs_lvds_rx
	import acs_pkg::*;
(
	input wire logic       ser_clk,
	input wire logic       longMode,
	input wire logic [7:0] serData,
	input wire logic       frame_clock,
	output acs_words_t     rxWords
);
	logic       fcPrev_ff;
	int         bitIdx;
	acs_words_t shift;
	initial begin
		fcPrev_ff = 1'b0;
		bitIdx = 0;
		rxWords = '0;
		shift = '0;
	end
	// frame start is the rising frame clock, lsb first on every lane
	always @(posedge ser_clk) begin
		bitIdx = (frame_clock && !fcPrev_ff) ? 0 : bitIdx + 1;
		fcPrev_ff <= frame_clock;
		for (int l = 0; l < 8; l++) begin
			if (bitIdx < 14) begin
				shift[l][bitIdx] = serData[l];
			end
		end
		if (bitIdx == (longMode ? 13 : 11)) begin
			for (int l = 0; l < 8; l++) begin
				rxWords[l] <= longMode ? shift[l] : {2'h0, shift[l][11:0]};
			end
		end
	end
endmodule : acs_lvds_rx

// File: test/acs_ctrl_top_bench.sv
// self-checking bench of the converter control top
`timescale 1ns/1ps

module acs_ctrl_top_bench;
	import acs_pkg::*;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] exp; logic err;} acs_row_t;
	logic        ref_clk, ser_clk, sys_rst, psel, penable, pwrite, pready, pslverr, longMode;
	logic        powerDownOut, deepSleepOut, dataValid, bitClk, frame_clock;
	logic [7:0]  paddr, serData;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0]  trim;
	logic [2:0]  pwr;
	logic [1:0]  cm;
	logic        e;
	acs_codes_t  convCode;
	acs_words_t  rxWords;
	int          err_total, checks_done, cyc, n;
	int          term[4] = '{992, 640, 420, 260};
	acs_row_t    rows[10] = '{
		'{0, 8'h04, 0, 32'h20, 0}, '{0, 8'h50, 0, 32'h10, 0}, '{1, 8'h04, 32'h3f, 32'h3f, 0},
		'{1, 8'h04, 32'h00, 32'h00, 0}, '{1, 8'h50, 32'h34, 32'h34, 0}, '{1, 8'h50, 32'h15, 32'h15, 0},
		'{1, 8'h50, 32'h27, 32'h27, 0}, '{1, 8'h50, 32'h06, 32'h06, 0}, '{1, 8'h50, 32'h13, 32'h16, 0},
		'{1, 8'h60, 32'hff, 32'h00, 1}};
	acs_ctrl_top acs_ctrl_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .ser_clk(ser_clk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .convCode(convCode), .full_scale_trim_code(trim), .powerLevel(pwr),
		.common_mode_buffer_strength(cm), .powerDownOut(powerDownOut), .deepSleepOut(deepSleepOut),
		.dataValid(dataValid), .serData(serData), .bitClk(bitClk), .frame_clock(frame_clock));
	acs_lvds_rx acs_lvds_rx_inst (.ser_clk(ser_clk), .longMode(longMode), .serData(serData),
		.frame_clock(frame_clock), .rxWords(rxWords));
	initial begin
		ref_clk = 0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// link clock offset so its edges never line up with the register clock
	initial begin
		ser_clk = 0;
		#3.3;
		forever #7.5 ser_clk = ~ser_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 12000) begin
			err_total++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		// this wait ends when pready is seen high, or else at the bench timeout
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	// leave low power via pd or deep-sleep, count edges until valid
	task automatic startup(input int r, input logic ds, input int abortAt);
		apb(1, 8'h00, r | (ds ? 8 : 4));
		if (abortAt > 0) begin
			apb(1, 8'h00, r);
			repeat (abortAt) @(posedge ref_clk);
			apb(1, 8'h00, r | 4);
		end
		repeat (5) @(posedge ref_clk);
		chk(dataValid, 0);
		apb(1, 8'h00, r);
		n = 0;
		while (dataValid !== 1'b1 && n < 1100) begin
			@(posedge ref_clk);
			n++;
		end
		chk(n >= term[r] - 1 && n <= term[r] + 4, 1);
		$display("test startup range %0d done, %0d cycles", r, n);
	endtask : startup
	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim
	initial begin
		{psel, penable, pwrite, paddr, pwdata, longMode, err_total, checks_done, cyc} = '0;
		sys_rst = 1;
		for (int l = 0; l < 8; l++) begin
			convCode[l] = (l == 0) ? 13'h0000 : (l == 7) ? 13'h1fff : 13'h0a5a + 13'(l * 37);
		end
		repeat (10) @(posedge ref_clk);
		sys_rst <= 0;
		repeat (3) @(posedge ref_clk);
		chk({trim, pwr, cm, dataValid}, {6'h20, 3'h0, 2'h1, 1'b1});
		$display("test reset done");
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				apb(1, rows[i].a, rows[i].d);
				chk(e, rows[i].err);
			end
			apb(0, rows[i].a, 0);
			chk(rd, rows[i].exp);
			chk(e, rows[i].err);
		end
		$display("test registers done");
		for (int r = 0; r < 4; r++) begin
			startup(r, r[0], 0);
		end
		startup(3, 0, 100);
		for (int m = 0; m < 2; m++) begin
			longMode <= m[0];
			apb(1, 8'h00, m ? 32'h10 : 32'h00);
			repeat (60) @(posedge ref_clk);
			for (int l = 0; l < 8; l++) begin
				chk(rxWords[l], m ? {convCode[l], 1'b0} : {2'h0, convCode[l][12:1]});
			end
			$display("test link mode %0d done", m);
		end
		// status: last count 259 of range 3, valid, sticky refusal from the reserved write
		apb(0, 8'h08, 0);
		chk(rd, 32'h0103_0006);
		apb(1, 8'h08, 32'h4);
		apb(0, 8'h08, 0);
		chk(rd, 32'h0103_0002);
		apb(0, 8'h0c, 0);
		chk(rd != 32'h0, 1);
		sys_rst <= 1;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 0;
		repeat (3) @(posedge ref_clk);
		chk({trim, pwr, cm, dataValid}, {6'h20, 3'h0, 2'h1, 1'b1});
		apb(0, 8'h08, 0);
		chk(rd, 32'h0000_0002);
		$display("test status and second reset done");
		end_sim();
	end
endmodule : acs_ctrl_top_bench
